// File: rtl/tcc_pkg.sv
// Package for the timer 3 capture/compare unit: register map and fields.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package tcc_pkg;
    localparam logic [15:0] TCC_OFS_CTRL = 16'hff7f;
    localparam logic [15:0] TCC_ADDR_CTRL = 16'h0000;
    localparam logic [15:0] TCC_ADDR_EDGE_LO = 16'h0004;
    localparam logic [15:0] TCC_ADDR_EDGE_HI = 16'h0008;
    localparam logic [15:0] TCC_ADDR_SMP_LO = 16'h000c;
    localparam logic [15:0] TCC_ADDR_SMP_HI = 16'h0010;
    localparam logic [15:0] TCC_ADDR_CCR = 16'h0014;
    localparam logic [15:0] TCC_ADDR_CAP_A = 16'h0018;
    localparam logic [15:0] TCC_ADDR_CAP_B = 16'h001c;
    localparam logic [15:0] TCC_ADDR_COUNT = 16'h0020;
    localparam logic [7:0] TCC_CTRL_MASK = 8'h9f;
    localparam logic [7:0] TCC_EDGE_LO_MASK = 8'hfd;
    localparam logic [7:0] TCC_EDGE_HI_MASK = 8'h0f;
    localparam logic [7:0] TCC_SMP_HI_MASK = 8'h03;
    localparam logic [7:0] TCC_REG_RST = 8'h00;
    localparam int TCC_BIT_RUN = 7;
    localparam int TCC_BIT_CCSEL = 4;
    localparam int TCC_BIT_CLREN = 3;
    localparam int TCC_FILT_LEN = 4;
    localparam logic [1:0] TCC_RESP_OKAY = 2'b00;
    localparam logic [1:0] TCC_RESP_SLVERR = 2'b10;
    localparam logic [15:0] TCC_CNT_ZERO = 16'h0000;
    localparam logic [15:0] TCC_CNT_MAX = 16'hffff;
    // Edge code: 00 falling, 01 rising, 10 none, 11 both edges.
    localparam logic [1:0] TCC_EDGE_FALL = 2'b00;
    localparam logic [1:0] TCC_EDGE_RISE = 2'b01;
    localparam logic [1:0] TCC_EDGE_BOTH = 2'b11;
    // Prescaler divider exponents for codes 000 to 101.
    function automatic logic [3:0] tcc_div_exp(input logic [2:0] code);
        case (code)
            3'h0: tcc_div_exp = 4'h2;
            3'h1: tcc_div_exp = 4'h3;
            3'h2: tcc_div_exp = 4'h4;
            3'h3: tcc_div_exp = 4'h5;
            3'h4: tcc_div_exp = 4'h6;
            3'h5: tcc_div_exp = 4'h8;
            default: tcc_div_exp = 4'h0;
        endcase
    endfunction : tcc_div_exp
    // Sample clock exponent for a 2-bit field: divide by 2, 4, 8, 16.
    function automatic logic [3:0] tcc_smp_exp(input logic [1:0] code);
        tcc_smp_exp = {2'b00, code} + 4'h1;
    endfunction : tcc_smp_exp
endpackage : tcc_pkg

// File: rtl/tcc_filter.sv
// Four-sample noise filter and edge detector for one input pin.
// Assumes a raw asynchronous pin and a one-cycle sample enable.
`timescale 1ns/1ps
module tcc_filter
    import tcc_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    // Pin, sampling strobe and edge choice.
    input wire logic pin_in,
    input wire logic smp_en_in,
    input wire logic [1:0] edge_sel_in,
    // Detected valid edge.
    output logic edge_out
);
    logic sync1_r;
    logic sync2_r;
    logic [TCC_FILT_LEN-1:0] hist_r;
    logic level_r;
    logic level_nxt;
    logic rise;
    logic fall;

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end

    // A level is taken only when four samples in a row agree.
    always_comb begin
        level_nxt = level_r;
        if (&hist_r) begin
            level_nxt = 1'b1;
        end else if (~|hist_r) begin
            level_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            hist_r <= '0;
            level_r <= 1'b0;
        end else begin
            if (smp_en_in) begin
                hist_r <= {hist_r[TCC_FILT_LEN-2:0], sync2_r};
            end
            level_r <= level_nxt;
        end
    end

    assign rise = level_nxt & ~level_r;
    assign fall = ~level_nxt & level_r;

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            edge_out <= 1'b0;
        end else begin
            case (edge_sel_in)
                TCC_EDGE_FALL: edge_out <= fall;
                TCC_EDGE_RISE: edge_out <= rise;
                TCC_EDGE_BOTH: edge_out <= rise | fall;
                default: edge_out <= 1'b0;
            endcase
        end
    end

    a_filter_reject: assert property (@(posedge clk_sys_in) disable iff
        (!nrst_in) (level_r != $past(level_r)) |-> (hist_r == {4{level_r}}))
        else $error("filter level changed without four agreeing samples");
endmodule : tcc_filter

// File: rtl/tcc_prescaler.sv
// Dividers giving count and sampling enable pulses; only the sampling one runs free.
// Assumes one system clock; all outputs are one-cycle enables.
`timescale 1ns/1ps
module tcc_prescaler
    import tcc_pkg::*;
#(
    parameter int DIV_W = 9
) (
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    // Hold the divider at zero while counting is stopped.
    input wire logic clear_in,
    // Divider exponent selects.
    input wire logic [3:0] exp_cnt_in,
    input wire logic [3:0] exp_a_in,
    input wire logic [3:0] exp_b_in,
    // Strobes.
    output logic cnt_en_out,
    output logic smp_a_out,
    output logic smp_b_out
);
    logic [DIV_W-1:0] div_r;
    logic [DIV_W-1:0] div_nxt;
    // Sampling runs free so the pin filters still work while stopped.
    logic [DIV_W-1:0] smp_r;

    function automatic logic tick(input logic [DIV_W-1:0] nxt,
                                  input logic [3:0] e);
        logic [DIV_W-1:0] msk;
        msk = DIV_W'((1 << e) - 1);
        tick = (e != 4'h0) && ((nxt & msk) == '0);
    endfunction : tick

    assign div_nxt = clear_in ? '0 : div_r + DIV_W'(1);

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            div_r <= '0;
            smp_r <= '0;
            cnt_en_out <= 1'b0;
            smp_a_out <= 1'b0;
            smp_b_out <= 1'b0;
        end else begin
            div_r <= div_nxt;
            smp_r <= smp_r + DIV_W'(1);
            cnt_en_out <= !clear_in && tick(div_nxt, exp_cnt_in);
            smp_a_out <= tick(smp_r + DIV_W'(1), exp_a_in);
            smp_b_out <= tick(smp_r + DIV_W'(1), exp_b_in);
        end
    end
endmodule : tcc_prescaler

// File: rtl/tcc_timer.sv
// Timer 3 top: 16-bit counter, capture/compare and capture registers,
// input filters and an AXI4-Lite register slave.
// Assumes synchronous AXI master on clk_sys_in and raw asynchronous pins.
//
// Contract
// - Counter advances on prescaled clock, divide by 4,8,16,32,64,256.
// - After run-enable set, first count clock gives 0000H, second 0001H.
// - Setting run-enable again while running does not clear the counter.
// - Clearing run-enable stops the counter and forces it to 0000H.
// - Reset clears the counter and leaves it stopped.
// - Select and clear-enable bits choose free-running/interval, capture/compare.
// - Compare match raises interrupt; counter clears on next count clock.
// - Capture-interval mode clears counter on valid primary input edge.
// - Free-running counts to FFFFH, raises overflow, wraps to 0000H.
// - Combined register captures the count on primary input edge.
// - Two capture registers latch the count on their own inputs.
// - Writes reach compare storage; reads return the selected storage.
// - In compare mode the primary input raises no interrupt.
// - Control bits 6 and 5 always read zero.
// - Two edge-mode registers pick active edges; both reset to 00H.
// - Edge-mode low bit 1 and high bits 7 to 4 read zero.
// - Inputs accepted after four agreeing samples on selected clock.
// - Sampling high bits 7 to 2 read zero; both reset to 00H.
// - Control register resets to 00H, timer stopped.
// - Compare match and primary input share one interrupt output.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
module tcc_timer
    import tcc_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    // AXI4-Lite write address and data.
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read.
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Capture trigger pins.
    input wire logic primary_capture_input_in,
    input wire logic second_capture_input_in,
    input wire logic third_capture_input_in,
    // Event pulses.
    output logic compare_match_irq_out,
    output logic overflow_irq_out,
    output logic second_capture_irq_out,
    output logic third_capture_irq_out
);
    logic [7:0] timer_control_r;
    logic [7:0] edge_mode_low_r;
    logic [7:0] edge_mode_high_r;
    logic [7:0] sample_clock_low_r;
    logic [7:0] sample_clock_high_r;
    logic [15:0] main_counter_r;
    logic [15:0] compare_r;
    logic [15:0] capture_compare_reg_r;
    logic [15:0] capture_reg_a_r;
    logic [15:0] capture_reg_b_r;
    logic started_r;
    logic match_hold_r;
    logic [15:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic aw_have_r;
    logic w_have_r;
    logic run_enable;
    logic cap_cmp_select;
    logic clear_enable;
    logic cnt_en;
    logic smp_a;
    logic smp_b;
    logic edge_p;
    logic edge_s;
    logic edge_t;
    logic match;
    logic wr_go;
    logic [31:0] rd_word;

    assign run_enable = timer_control_r[TCC_BIT_RUN];
    assign cap_cmp_select = timer_control_r[TCC_BIT_CCSEL];
    assign clear_enable = timer_control_r[TCC_BIT_CLREN];

    // Sample clock A serves the primary and second pins from the low sampling
    // register field; the high register gives the third pin its own rate.
    tcc_prescaler #(.DIV_W(9)) u_presc (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .clear_in(!run_enable),
        .exp_cnt_in(tcc_div_exp(timer_control_r[2:0])),
        .exp_a_in(tcc_smp_exp(sample_clock_low_r[1:0])),
        .exp_b_in(tcc_smp_exp(sample_clock_high_r[1:0])),
        .cnt_en_out(cnt_en),
        .smp_a_out(smp_a),
        .smp_b_out(smp_b)
    );

    tcc_filter u_filt_p (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .pin_in(primary_capture_input_in),
        .smp_en_in(smp_a),
        .edge_sel_in(edge_mode_low_r[3:2]),
        .edge_out(edge_p)
    );

    tcc_filter u_filt_s (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .pin_in(second_capture_input_in),
        .smp_en_in(smp_a),
        .edge_sel_in(edge_mode_low_r[5:4]),
        .edge_out(edge_s)
    );

    tcc_filter u_filt_t (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .pin_in(third_capture_input_in),
        .smp_en_in(smp_b),
        .edge_sel_in(edge_mode_high_r[3:2]),
        .edge_out(edge_t)
    );

    assign match = cap_cmp_select && (main_counter_r == compare_r);

    // Counter. The first count clock after start keeps 0000H.
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            main_counter_r <= TCC_CNT_ZERO;
            started_r <= 1'b0;
            match_hold_r <= 1'b0;
        end else if (!run_enable) begin
            main_counter_r <= TCC_CNT_ZERO;
            started_r <= 1'b0;
            match_hold_r <= 1'b0;
        end else if (!cap_cmp_select && clear_enable && edge_p) begin
            main_counter_r <= TCC_CNT_ZERO;
            started_r <= 1'b1;
        end else if (cnt_en) begin
            started_r <= 1'b1;
            match_hold_r <= 1'b0;
            if (!started_r) begin
                main_counter_r <= TCC_CNT_ZERO;
            end else if (clear_enable && cap_cmp_select
                         && (match_hold_r || match)) begin
                main_counter_r <= TCC_CNT_ZERO;
            end else begin
                main_counter_r <= main_counter_r + 16'h0001;
            end
        end else if (match && clear_enable) begin
            match_hold_r <= 1'b1;
        end
    end

    // Events. Match is taken once per count value, at its count clock.
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            compare_match_irq_out <= 1'b0;
            overflow_irq_out <= 1'b0;
            second_capture_irq_out <= 1'b0;
            third_capture_irq_out <= 1'b0;
        end else begin
            compare_match_irq_out <= (cap_cmp_select
                ? (run_enable && cnt_en && started_r && match)
                : edge_p);
            overflow_irq_out <= run_enable && cnt_en && started_r
                && !clear_enable && (main_counter_r == TCC_CNT_MAX);
            second_capture_irq_out <= edge_s;
            third_capture_irq_out <= edge_t;
        end
    end

    // Capture storage has no reset value in use; it is cleared for safety.
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            capture_compare_reg_r <= TCC_CNT_ZERO;
            capture_reg_a_r <= TCC_CNT_ZERO;
            capture_reg_b_r <= TCC_CNT_ZERO;
        end else begin
            if (edge_p && !cap_cmp_select) begin
                capture_compare_reg_r <= main_counter_r;
            end
            if (edge_s) begin
                capture_reg_a_r <= main_counter_r;
            end
            if (edge_t) begin
                capture_reg_b_r <= main_counter_r;
            end
        end
    end

    // Write channel: address and data accepted in either order.
    assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= '0;
            w_strb_r <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= TCC_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_have_r && !s_axi_awready;
            s_axi_wready <= !w_have_r && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_r <= TCC_ADDR_CCR
                    && aw_addr_r[1:0] == 2'b00)
                    ? TCC_RESP_OKAY : TCC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register writes; fixed-zero bits are masked off.
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            timer_control_r <= TCC_REG_RST;
            edge_mode_low_r <= TCC_REG_RST;
            edge_mode_high_r <= TCC_REG_RST;
            sample_clock_low_r <= TCC_REG_RST;
            sample_clock_high_r <= TCC_REG_RST;
            compare_r <= TCC_CNT_ZERO;
        end else if (wr_go && w_strb_r[0]) begin
            case (aw_addr_r)
                TCC_ADDR_CTRL:
                    timer_control_r <= w_data_r[7:0] & TCC_CTRL_MASK;
                TCC_ADDR_EDGE_LO:
                    edge_mode_low_r <= w_data_r[7:0] & TCC_EDGE_LO_MASK;
                TCC_ADDR_EDGE_HI:
                    edge_mode_high_r <= w_data_r[7:0] & TCC_EDGE_HI_MASK;
                TCC_ADDR_SMP_LO: sample_clock_low_r <= w_data_r[7:0];
                TCC_ADDR_SMP_HI:
                    sample_clock_high_r <= w_data_r[7:0] & TCC_SMP_HI_MASK;
                TCC_ADDR_CCR: begin
                    if (w_strb_r[1]) begin
                        compare_r <= w_data_r[15:0];
                    end
                end
                default: compare_r <= compare_r;
            endcase
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        case (s_axi_araddr)
            TCC_ADDR_CTRL: rd_word[7:0] = timer_control_r;
            TCC_ADDR_EDGE_LO: rd_word[7:0] = edge_mode_low_r;
            TCC_ADDR_EDGE_HI: rd_word[7:0] = edge_mode_high_r;
            TCC_ADDR_SMP_LO: rd_word[7:0] = sample_clock_low_r;
            TCC_ADDR_SMP_HI: rd_word[7:0] = sample_clock_high_r;
            TCC_ADDR_CCR: rd_word[15:0] = cap_cmp_select
                ? compare_r : capture_compare_reg_r;
            TCC_ADDR_CAP_A: rd_word[15:0] = capture_reg_a_r;
            TCC_ADDR_CAP_B: rd_word[15:0] = capture_reg_b_r;
            TCC_ADDR_COUNT: rd_word[15:0] = main_counter_r;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= TCC_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= (s_axi_araddr <= TCC_ADDR_COUNT
                    && s_axi_araddr[1:0] == 2'b00)
                    ? TCC_RESP_OKAY : TCC_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    a_stop_clears: assert property (@(posedge clk_sys_in) disable iff
        (!nrst_in) !run_enable |=> main_counter_r == TCC_CNT_ZERO)
        else $error("counter not zero while stopped");
    a_first_tick: assert property (@(posedge clk_sys_in) disable iff
        (!nrst_in) (cnt_en && run_enable && !started_r && !edge_p)
        |=> main_counter_r == TCC_CNT_ZERO)
        else $error("first count clock did not hold zero");
    a_count_step: assert property (@(posedge clk_sys_in) disable iff
        (!nrst_in) (cnt_en && run_enable && started_r && !clear_enable)
        |=> main_counter_r == $past(main_counter_r) + 16'h0001)
        else $error("free count did not step by one");
    a_cmp_clear: assert property (@(posedge clk_sys_in) disable iff
        (!nrst_in) (cnt_en && run_enable && started_r && match
        && clear_enable && !edge_p) |=> main_counter_r == TCC_CNT_ZERO)
        else $error("interval compare did not clear");
    a_cap_clear: assert property (@(posedge clk_sys_in) disable iff
        (!nrst_in) (run_enable && !cap_cmp_select && clear_enable && edge_p)
        |=> main_counter_r == TCC_CNT_ZERO)
        else $error("capture edge did not clear counter");
    a_cap_latch: assert property (@(posedge clk_sys_in) disable iff
        (!nrst_in) edge_s |=> capture_reg_a_r == $past(main_counter_r))
        else $error("capture a missed the count");
    a_ccr_latch: assert property (@(posedge clk_sys_in) disable iff
        (!nrst_in) (edge_p && !cap_cmp_select)
        |=> capture_compare_reg_r == $past(main_counter_r))
        else $error("combined capture missed the count");
    a_ctrl_zero: assert property (@(posedge clk_sys_in) disable iff
        (!nrst_in) timer_control_r[6:5] == 2'b00 && edge_mode_low_r[1] == 1'b0
        && edge_mode_high_r[7:4] == 4'h0 && sample_clock_high_r[7:2] == 6'h00)
        else $error("fixed-zero bit set");
    a_no_pin_irq: assert property (@(posedge clk_sys_in) disable iff
        (!nrst_in) (cap_cmp_select
        && !(run_enable && cnt_en && started_r && match))
        |=> !compare_match_irq_out)
        else $error("primary input raised interrupt in compare mode");
endmodule : tcc_timer

// File: testbench/tcc_pin_model.sv
// Model of the three capture trigger pins outside the timer.
// Assumes single-cycle requests from the bench; widths are in clocks.
`timescale 1ns/1ps
module tcc_pin_model (
    // Clock.
    input wire logic clk_sys_in,
    // Pulse request and width.
    input wire logic [2:0] req_in,
    input wire logic [7:0] len_in,
    // Pin levels, idle low.
    output logic [2:0] pins_out
);
    logic [7:0] left_r = 8'h0;
    initial pins_out = 3'h0;
    // The bench picks the width, so a short one is a noise test.
    always @(posedge clk_sys_in) begin
        if (req_in != 3'h0) begin
            pins_out <= req_in;
            left_r <= len_in - 8'h1;
        end else if (left_r != 8'h0) begin
            left_r <= left_r - 8'h1;
        end else begin
            pins_out <= 3'h0;
        end
    end
endmodule : tcc_pin_model

// File: testbench/tcc_timer_tb_top.sv
// Bench for the timer: register tasks, pin pulses and expected values.
// Assumes the pin model drives the three capture inputs.
`timescale 1ns/1ps
module tcc_timer_tb_top;
    import tcc_pkg::*;
    logic clk_sys_in = 1'h0;
    logic nrst_in = 1'h0;
    logic [15:0] awaddr = 16'h0;
    logic [15:0] araddr = 16'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic awv = 1'h0, wv = 1'h0, bre = 1'h0, arv = 1'h0, rre = 1'h0;
    logic awr, wrdy, bv, arr, rv, cm, ov, s2, s3;
    logic [1:0] bresp, rresp, rsp;
    logic [2:0] pins, req = 3'h0;
    logic [7:0] len = 8'h0;
    logic [31:0] v, w;
    logic [15:0] ta [4] = '{TCC_ADDR_CTRL, TCC_ADDR_EDGE_LO,
        TCC_ADDR_EDGE_HI, TCC_ADDR_SMP_HI};
    logic [31:0] te [4] = '{32'h1f, 32'h7d, 32'h0f, 32'h03};
    int errors = 0, n_checks = 0, cm_n = 0, s2_n = 0, s3_n = 0, ov_n = 0;
    time t0, t1;
    always #5 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) begin
        cm_n += int'(cm);
        s2_n += int'(s2);
        s3_n += int'(s3);
        ov_n += int'(ov);
    end
    tcc_timer tcc_timer_inst (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(bre), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rre),
        .primary_capture_input_in(pins[0]),
        .second_capture_input_in(pins[1]),
        .third_capture_input_in(pins[2]), .compare_match_irq_out(cm),
        .overflow_irq_out(ov), .second_capture_irq_out(s2),
        .third_capture_irq_out(s3));
    tcc_pin_model tcc_pin_model_inst (.clk_sys_in(clk_sys_in),
        .req_in(req), .len_in(len), .pins_out(pins));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awv <= 1'h1;
        wv <= 1'h1;
        bre <= 1'h1;
        do begin
            @(posedge clk_sys_in);
            if (awv && awr) awv <= 1'h0;
            if (wv && wrdy) wv <= 1'h0;
        end while (!bv);
        bre <= 1'h0;
        @(posedge clk_sys_in);
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        araddr <= a;
        arv <= 1'h1;
        rre <= 1'h1;
        do begin
            @(posedge clk_sys_in);
            if (arv && arr) arv <= 1'h0;
        end while (!rv);
        d = rdata;
        rsp = rresp;
        rre <= 1'h0;
        @(posedge clk_sys_in);
    endtask : rd
    task automatic pulse(input logic [2:0] sel, input logic [7:0] l);
        req <= sel;
        len <= l;
        @(posedge clk_sys_in);
        req <= 3'h0;
        repeat (60) @(posedge clk_sys_in);
    endtask : pulse
    task automatic wirq(output time t);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (cm !== 1'h1 && n < 300);
        t = $time;
    endtask : wirq
    task automatic wrap_up;
        $display("Checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        errors++;
        wrap_up;
    end
    initial begin
        repeat (8) @(posedge clk_sys_in);
        nrst_in <= 1'h1;
        @(posedge clk_sys_in);
        for (int i = 0; i < 5; i++) begin
            rd(16'(i * 4), v);
            chk(v, 32'h0);
        end
        for (int i = 0; i < 4; i++) begin
            wr(ta[i], 32'h7f);
            rd(ta[i], v);
            chk(v, te[i]);
            wr(ta[i], 32'h0);
        end
        rd(16'h0040, v);
        chk(32'(rsp), 32'(TCC_RESP_SLVERR));
        wr(TCC_ADDR_CCR, 32'h5);
        wr(TCC_ADDR_CTRL, 32'h98);
        rd(TCC_ADDR_CCR, v);
        chk(v, 32'h5);
        wirq(t0);
        wirq(t1);
        chk(32'((t1 - t0) / 10), 32'd24);
        wr(TCC_ADDR_CTRL, 32'h18);
        rd(TCC_ADDR_COUNT, v);
        chk(v, 32'h0);
        wr(TCC_ADDR_EDGE_LO, 32'h14);
        wr(TCC_ADDR_EDGE_HI, 32'h04);
        v = 32'(cm_n);
        pulse(3'h1, 8'h14);
        chk(32'(cm_n) - v, 32'h0);
        wr(TCC_ADDR_CTRL, 32'h08);
        wr(TCC_ADDR_CTRL, 32'h88);
        rd(TCC_ADDR_COUNT, v);
        repeat (20) @(posedge clk_sys_in);
        wr(TCC_ADDR_CTRL, 32'h88);
        rd(TCC_ADDR_COUNT, w);
        chk(32'(w > v), 32'h1);
        repeat (200) @(posedge clk_sys_in);
        v = 32'(cm_n);
        pulse(3'h1, 8'h14);
        chk(32'(cm_n) - v, 32'h1);
        rd(TCC_ADDR_COUNT, v);
        chk(32'(v < 32'd24), 32'h1);
        rd(TCC_ADDR_CCR, v);
        chk(32'(v > 32'h20), 32'h1);
        pulse(3'h6, 8'h14);
        chk(32'(s2_n), 32'h1);
        chk(32'(s3_n), 32'h1);
        rd(TCC_ADDR_CAP_A, v);
        chk(32'(v != 32'h0), 32'h1);
        pulse(3'h2, 8'h3);
        chk(32'(s2_n), 32'h1);
        rd(TCC_ADDR_CAP_B, v);
        chk(32'(v != 32'h0), 32'h1);
        wr(TCC_ADDR_CTRL, 32'h08);
        wr(TCC_ADDR_CTRL, 32'h00);
        wr(TCC_ADDR_CTRL, 32'h80);
        repeat (100) @(posedge clk_sys_in);
        v = 32'(cm_n);
        pulse(3'h1, 8'h14);
        chk(32'(cm_n) - v, 32'h1);
        rd(TCC_ADDR_COUNT, v);
        chk(32'(v > 32'd30), 32'h1);
        chk(32'(ov_n), 32'h0);
        wrap_up;
    end
endmodule : tcc_timer_tb_top
